// File: src/angle_sensor_end.sv
// Purpose: sensor end: samples angle, shifts it out msb first per serial clock rise
// Assumes: host keeps select/clock timing; link pins sampled by two flops
// Notes:   pin sync adds 2-3 cycles latency, well inside 100 ns and 375 ns bounds
module angle_sensor_end
    import angle_link_pkg::*;
#(
    parameter int NBITS       = POS_BITS_12,
    parameter int SAMPLE_CYC  = SAMPLE_PERIOD_CYC,
    parameter int POWERUP_CYC = (NBITS == POS_BITS_12) ? POWERUP_12_CYC : POWERUP_10_CYC
)(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [POS_W-1:0] angle_i,
    angle_link_if.sensor          link,
    output logic                  ready_o,
    output logic [POS_W-1:0]      sample_o
);
    typedef enum logic [1:0] {IDLE, DRIVE, SHIFT, DONE} sstate_e;
    localparam logic [POS_W-1:0] POS_MASK = POS_W'((1 << NBITS) - 1);

    logic [1:0]       sel_sync_reg, clk_sync_reg;
    logic [POS_W-1:0] angle_meta_reg, angle_sync_reg;
    logic             clk_prev_reg;
    sstate_e          state_reg, state_next;
    logic [POS_W-1:0] shift_reg, shift_next;
    logic [4:0]       cnt_reg, cnt_next;
    logic             data_reg, data_next;
    logic             oe_reg, oe_next;
    logic [31:0]      samp_cnt_reg, samp_cnt_next;
    logic [POS_W-1:0] sample_reg, sample_next;
    logic [31:0]      pwr_cnt_reg, pwr_cnt_next;
    logic             ready_reg, ready_next;
    logic             sel_low, clk_rise;

    // x or z on select treated as high
    assign sel_low  = (sel_sync_reg[1] === 1'b0);
    assign clk_rise = clk_sync_reg[1] & ~clk_prev_reg;

    // sampler free-runs; a read-out never restarts it
    always_comb
    begin
        samp_cnt_next = samp_cnt_reg + 32'h1;
        sample_next   = sample_reg;
        if (samp_cnt_reg >= 32'(SAMPLE_CYC - 1))
        begin
            samp_cnt_next = 32'h0;
            sample_next   = angle_sync_reg & POS_MASK;
        end
    end

    always_comb
    begin
        pwr_cnt_next = pwr_cnt_reg;
        ready_next   = ready_reg;
        if (!ready_reg)
        begin
            pwr_cnt_next = pwr_cnt_reg + 32'h1;
            if (pwr_cnt_reg >= 32'(POWERUP_CYC - 1))
                ready_next = 1'b1;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next   = cnt_reg;
        data_next  = data_reg;
        oe_next    = oe_reg;
        case (state_reg)
            IDLE:
            begin
                oe_next = 1'b0;
                if (sel_low)
                begin
                    state_next = DRIVE;
                    oe_next    = 1'b1;
                    data_next  = 1'b1;
                    // the frame keeps the sample held at the select fall
                    shift_next = sample_reg << (POS_W - NBITS);
                    cnt_next   = 5'(NBITS);
                end
            end
            DRIVE, SHIFT:
            begin
                if (!sel_low)
                begin
                    state_next = IDLE;
                    oe_next    = 1'b0;
                end
                else if (clk_rise)
                begin
                    if (cnt_reg == 5'h0)
                    begin
                        state_next = DONE;
                        oe_next    = 1'b0;
                    end
                    else
                    begin
                        state_next = SHIFT;
                        data_next  = shift_reg[POS_W-1];
                        shift_next = shift_reg << 1;
                        cnt_next   = cnt_reg - 5'h1;
                    end
                end
            end
            DONE:
            begin
                // further rises are ignored until select returns high
                oe_next = 1'b0;
                if (!sel_low)
                    state_next = IDLE;
            end
            default:
            begin
                state_next = IDLE;
                oe_next    = 1'b0;
            end
        endcase
    end

    // the link clock idles high, so its edge finder starts high: no false rise
    // the angle is a slow level; a word caught mid-change may mix two readings
    // for one sample, traded for not needing a handshake on the sensing side
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sel_sync_reg   <= 2'h3;
            clk_sync_reg   <= 2'h3;
            clk_prev_reg   <= 1'b1;
            angle_meta_reg <= POS_RESET;
            angle_sync_reg <= POS_RESET;
        end
        else
        begin
            sel_sync_reg   <= {sel_sync_reg[0], link.select_low};
            clk_sync_reg   <= {clk_sync_reg[0], link.serial_clk};
            clk_prev_reg   <= clk_sync_reg[1];
            angle_meta_reg <= angle_i;
            angle_sync_reg <= angle_meta_reg;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            samp_cnt_reg <= 32'h0;
            sample_reg   <= POS_RESET;
        end
        else
        begin
            samp_cnt_reg <= samp_cnt_next;
            sample_reg   <= sample_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pwr_cnt_reg <= 32'h0;
            ready_reg   <= 1'b0;
        end
        else
        begin
            pwr_cnt_reg <= pwr_cnt_next;
            ready_reg   <= ready_next;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= IDLE;
            shift_reg <= POS_RESET;
            cnt_reg   <= 5'h0;
            data_reg  <= 1'b0;
            oe_reg    <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg   <= cnt_next;
            data_reg  <= data_next;
            oe_reg    <= oe_next;
        end
    end

    assign link.data_o  = data_reg;
    assign link.data_oe = oe_reg;
    assign ready_o      = ready_reg;
    assign sample_o     = sample_reg;
endmodule

// File: src/angle_link_pkg.sv
// Purpose: shared constants for the angle sensor serial read-out link
// Assumes: both ends run on clk_i at 100 MHz
// Notes:   times are kept in their own unit, cycle counts derive from them
package angle_link_pkg;
    localparam int CLK_PERIOD_NS        = 10;
    localparam int DRIVE_ACTIVE_MAX_NS  = 100;
    localparam int SELECT_TO_CLK_MIN_NS = 500;
    localparam int DATA_VALID_MAX_NS    = 375;
    localparam int TRISTATE_MAX_NS      = 100;
    localparam int SELECT_HIGH_MIN_NS   = 500;
    localparam int SAMPLE_RATE_HZ       = 10420;
    localparam int POWERUP_10_MS        = 50;
    localparam int POWERUP_12_MS        = 20;
    localparam int LINK_CLK_MAX_HZ      = 1000000;
    localparam int CLK_HZ               = 1000000000 / CLK_PERIOD_NS;
    // least times round up, longest round down, except the data valid time, which rounds up
    localparam int SELECT_TO_CLK_CYC = (SELECT_TO_CLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DATA_VALID_CYC    = (DATA_VALID_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELECT_HIGH_CYC   = (SELECT_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DRIVE_ACTIVE_CYC  = DRIVE_ACTIVE_MAX_NS / CLK_PERIOD_NS;
    localparam int TRISTATE_CYC      = TRISTATE_MAX_NS / CLK_PERIOD_NS;
    localparam int HALF_PERIOD_CYC   = (CLK_HZ / LINK_CLK_MAX_HZ + 1) / 2;
    localparam int SAMPLE_PERIOD_CYC = CLK_HZ / SAMPLE_RATE_HZ;
    localparam int POWERUP_10_CYC    = POWERUP_10_MS * (CLK_HZ / 1000);
    localparam int POWERUP_12_CYC    = POWERUP_12_MS * (CLK_HZ / 1000);
    localparam int POS_BITS_12       = 12;
    localparam int POS_BITS_10       = 10;
    localparam int POS_W             = 12;
    localparam logic [POS_W-1:0] POS_RESET = 12'h000;
endpackage

// File: src/angle_link_if.sv
// Purpose: wires between sensor end and host end
// Assumes: serial data is three-state; the bench resolves the wire from data_oe
// Notes:   select_low is read as high by the sensor when nobody drives it
interface angle_link_if;
    logic select_low;
    logic serial_clk;
    logic data_o;
    logic data_oe;
    modport sensor (input select_low, input serial_clk, output data_o, output data_oe);
    modport host   (output select_low, output serial_clk, input data_o, input data_oe);
endinterface

// File: src/angle_fifo.sv
// Purpose: small valid/ready fifo for received positions
// Assumes: single clock
// Notes:   depth must be a power of two
module angle_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
)(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
    logic             full, empty, push, pop;

    assign full  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    assign empty = (wr_reg == rd_reg);
    assign push  = in_valid_i & ~full;
    assign pop   = out_ready_i & ~empty;

    always_comb
    begin
        wr_next = push ? wr_reg + 1'b1 : wr_reg;
        rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wr_reg[AW-1:0]] <= in_data_i;
    end

    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o  = mem[rd_reg[AW-1:0]];
endmodule

// File: src/angle_host_end.sv
// Purpose: host end: frames a read-out, makes the serial clock, collects bits
// Assumes: sensor sits on the same interface
// Notes:   a frame is only started while the fifo has room, so no word is lost
module angle_host_end
    import angle_link_pkg::*;
#(
    parameter int NBITS       = POS_BITS_12,
    parameter int FIFO_DEPTH  = 8,
    parameter int POWERUP_CYC = (NBITS == POS_BITS_12) ? POWERUP_12_CYC : POWERUP_10_CYC
)(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    angle_link_if.host       link,
    input  wire logic        start_i,
    output logic [POS_W-1:0] pos_o,
    output logic             pos_valid_o,
    input  wire logic        pos_ready_i,
    output logic             busy_o
);
    typedef enum logic [2:0] {WAIT_PWR, IDLE, SETUP, CLK_HI, CLK_LO, GAP} hstate_e;

    logic [1:0]       d_sync_reg;
    hstate_e          state_reg, state_next;
    logic [31:0]      tmr_reg, tmr_next;
    logic [4:0]       bit_reg, bit_next;
    logic [POS_W-1:0] acc_reg, acc_next;
    logic             sel_reg, sel_next, sclk_reg, sclk_next, push_reg, push_next;
    logic             fifo_ready;
    logic             busy_reg, busy_next;

    always_comb
    begin
        state_next = state_reg;
        tmr_next   = (tmr_reg == 32'h0) ? 32'h0 : tmr_reg - 32'h1;
        bit_next   = bit_reg;
        acc_next   = acc_reg;
        sel_next   = sel_reg;
        sclk_next  = sclk_reg;
        push_next  = 1'b0;
        case (state_reg)
            WAIT_PWR:
                if (tmr_reg == 32'h0)
                    state_next = IDLE;
            IDLE:
                if (start_i && fifo_ready)
                begin
                    sel_next   = 1'b0;
                    state_next = SETUP;
                    tmr_next   = 32'(SELECT_TO_CLK_CYC);
                    bit_next   = 5'(NBITS);
                    acc_next   = POS_RESET;
                end
            SETUP:
                // clock idles high: the first action of a frame is a fall
                if (tmr_reg == 32'h0)
                begin
                    sclk_next  = 1'b0;
                    state_next = CLK_LO;
                    tmr_next   = 32'(HALF_PERIOD_CYC);
                end
            CLK_LO:
                if (tmr_reg == 32'h0)
                begin
                    sclk_next  = 1'b1;
                    state_next = CLK_HI;
                    tmr_next   = 32'(HALF_PERIOD_CYC);
                end
            CLK_HI:
                // half period exceeds the 375 ns valid time plus pin sync;
                // the rise after the last bit lets the sensor release the line
                if (tmr_reg == 32'h0)
                begin
                    if (bit_reg == 5'h0)
                    begin
                        sel_next   = 1'b1;
                        push_next  = 1'b1;
                        state_next = GAP;
                        tmr_next   = 32'(SELECT_HIGH_CYC);
                    end
                    else
                    begin
                        sclk_next  = 1'b0;
                        acc_next   = {acc_reg[POS_W-2:0], d_sync_reg[1]};
                        bit_next   = bit_reg - 5'h1;
                        state_next = CLK_LO;
                        tmr_next   = 32'(HALF_PERIOD_CYC);
                    end
                end
            GAP:
            begin
                sclk_next = 1'b1;
                if (tmr_reg == 32'h0)
                    state_next = IDLE;
            end
            default:
                state_next = IDLE;
        endcase
        busy_next = (state_next != IDLE);
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            d_sync_reg <= 2'h0;
            state_reg  <= WAIT_PWR;
            tmr_reg    <= 32'(POWERUP_CYC);
            bit_reg    <= 5'h0;
            acc_reg    <= POS_RESET;
            sel_reg    <= 1'b1;
            sclk_reg   <= 1'b1;
            push_reg   <= 1'b0;
            busy_reg   <= 1'b1;
        end
        else
        begin
            d_sync_reg <= {d_sync_reg[0], link.data_o & link.data_oe};
            state_reg  <= state_next;
            tmr_reg    <= tmr_next;
            bit_reg    <= bit_next;
            acc_reg    <= acc_next;
            sel_reg    <= sel_next;
            sclk_reg   <= sclk_next;
            push_reg   <= push_next;
            busy_reg   <= busy_next;
        end
    end

    angle_fifo #(.WIDTH(POS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (acc_reg),
        .in_valid_i  (push_reg),
        .in_ready_o  (fifo_ready),
        .out_data_o  (pos_o),
        .out_valid_o (pos_valid_o),
        .out_ready_i (pos_ready_i)
    );

    assign link.select_low = sel_reg;
    assign link.serial_clk = sclk_reg;
    assign busy_o          = busy_reg;
endmodule

// File: tb/angle_link_props.sv
// Purpose: link timing checks between the two ends
// Assumes: clk_i at 100 MHz
// Notes:   ages saturate so long idle spans stay legal
module angle_link_props #(
    parameter int NBITS = 12
)(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic select_low,
    input wire logic serial_clk,
    input wire logic data_o,
    input wire logic data_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] sel_age_reg;
    logic [7:0] rise_age_reg;
    logic [4:0] rise_cnt_reg;
    logic       sel_prev_reg;
    logic       clk_prev_reg;
    wire        rise_now = serial_clk && !clk_prev_reg;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sel_prev_reg <= 1'b1;
            clk_prev_reg <= 1'b1;
            sel_age_reg  <= 8'hff;
            rise_age_reg <= 8'hff;
            rise_cnt_reg <= 5'h00;
        end
        else
        begin
            sel_prev_reg <= select_low;
            clk_prev_reg <= serial_clk;
            if (select_low != sel_prev_reg)
                sel_age_reg <= 8'h01;
            else if (sel_age_reg != 8'hff)
                sel_age_reg <= sel_age_reg + 8'h01;
            if (rise_now)
                rise_age_reg <= 8'h01;
            else if (rise_age_reg != 8'hff)
                rise_age_reg <= rise_age_reg + 8'h01;
            rise_cnt_reg <= select_low ? 5'h00 : rise_cnt_reg + 5'(rise_now);
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence sel_fall;
        !select_low && sel_prev_reg;
    endsequence
    sequence lead_high;
        (data_oe && data_o) [*8];
    endsequence
    a_drive_on_select: assert property (sel_fall |-> ##[1:10] lead_high)
        else $error("select fall not answered");
    a_clk_setup: assert property (!serial_clk && clk_prev_reg |-> select_low || sel_age_reg >= 8'h32)
        else $error("clock fell too soon");
    a_select_gap: assert property (sel_fall |-> sel_age_reg >= 8'h32)
        else $error("select high too short");
    a_clk_high_time: assert property (!serial_clk && clk_prev_reg |-> rise_age_reg >= 8'h32)
        else $error("clock high too short");
    a_oe_in_frame: assert property (!select_low && rise_cnt_reg != 5'h00 && rise_cnt_reg <= NBITS |-> data_oe)
        else $error("bit not driven");
    a_bit_settle: assert property (data_oe && $past(data_oe) && $changed(data_o) |-> rise_age_reg <= 8'h25)
        else $error("bit changed late");
    a_tristate_end: assert property (rise_now && !select_low && rise_cnt_reg == NBITS |-> ##[1:10] !data_oe)
        else $error("no release after last bit");
    a_release_sel: assert property ($rose(select_low) |-> ##[1:10] !data_oe)
        else $error("no release after select");
endmodule

// File: tb/test_angle_sensor_serial_readout.sv
// Purpose: both link ends run against each other from their user sides
// Assumes: power-up and sample periods shortened by parameters
// Notes:   bits are also decoded from the wire, not only via the fifo
module test_angle_sensor_serial_readout
    import angle_link_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PWR = 100;
    localparam int SMP = 64;
    logic             clk_i, rst_n_i, start_i, pos_ready_i, ready_o, pos_valid_o, busy_o;
    logic             clk_seen = 1'b1;
    logic [POS_W-1:0] angle_i, sample_o, pos_o, wire_word;
    logic [11:0]      vals [5] = '{12'hfff, 12'h000, 12'ha5c, 12'h801, 12'h001};
    int               bad_count, checked, wire_n, age, n, q;
    logic             start10_i, pos10_ready_i, ready10_o, pos10_valid_o, busy10_o;
    logic [POS_W-1:0] sample10_o, pos10_o;
    angle_link_if link10 ();
    angle_link_if link ();
    angle_sensor_end #(.NBITS(12), .SAMPLE_CYC(SMP), .POWERUP_CYC(PWR)) i_angle_sensor_end (
        .clk_i, .rst_n_i, .angle_i, .link, .ready_o, .sample_o);
    angle_host_end #(.NBITS(12), .FIFO_DEPTH(8), .POWERUP_CYC(PWR)) i_angle_host_end (
        .clk_i, .rst_n_i, .link, .start_i, .pos_o, .pos_valid_o, .pos_ready_i, .busy_o);
    angle_link_props #(.NBITS(12)) i_angle_link_props (
        .clk_i, .rst_n_i, .select_low(link.select_low), .serial_clk(link.serial_clk),
        .data_o(link.data_o), .data_oe(link.data_oe));
    // narrow variant on a link of its own
    angle_sensor_end #(.NBITS(10), .SAMPLE_CYC(SMP), .POWERUP_CYC(PWR)) i_angle_sensor_end_10 (
        .clk_i, .rst_n_i, .angle_i, .link(link10), .ready_o(ready10_o), .sample_o(sample10_o));
    angle_host_end #(.NBITS(10), .FIFO_DEPTH(8), .POWERUP_CYC(PWR)) i_angle_host_end_10 (
        .clk_i, .rst_n_i, .link(link10), .start_i(start10_i), .pos_o(pos10_o),
        .pos_valid_o(pos10_valid_o), .pos_ready_i(pos10_ready_i), .busy_o(busy10_o));
    angle_link_props #(.NBITS(10)) i_angle_link_props_10 (
        .clk_i, .rst_n_i, .select_low(link10.select_low), .serial_clk(link10.serial_clk),
        .data_o(link10.data_o), .data_oe(link10.data_oe));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // take each bit 40 cycles after its rise, well past the valid time
    always @(posedge clk_i)
    begin
        age = (link.serial_clk && !clk_seen) ? 0 : age + 1;
        clk_seen = link.serial_clk;
        if (age == 40 && link.data_oe)
        begin
            wire_word = {wire_word[10:0], link.data_o};
            wire_n++;
        end
    end
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    task automatic pop(input logic [11:0] exp);
        check(12'(pos_valid_o), 12'h001);
        check(pos_o, exp);
        pos_ready_i = 1'b1;
        step(1);
        pos_ready_i = 1'b0;
        step(1);
    endtask
    task automatic frame(input logic [11:0] a);
        angle_i = a;
        step(2 * SMP + 4);
        check(sample_o, a);
        wire_n = 0;
        start_i = 1'b1;
        for (n = 0; n < 200 && busy_o !== 1'b1; n++) step(1);
        start_i = 1'b0;
        for (n = 0; n < 3000 && pos_valid_o !== 1'b1; n++) step(1);
        check(wire_word, a);
        check(12'(wire_n), 12'h00c);
        pop(a);
        for (n = 0; n < 200 && busy_o !== 1'b0; n++) step(1);
    endtask
    task automatic stop_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        rst_n_i = 1'b0;
        start_i = 1'b1;
        pos_ready_i = 1'b0;
        start10_i = 1'b0;
        pos10_ready_i = 1'b0;
        angle_i = 12'h3c5;
        repeat (5) @(posedge clk_i);
        #1;
        check(12'(link.select_low), 12'h001);
        check(12'(link.data_oe), 12'h000);
        check(12'(busy_o), 12'h001);
        rst_n_i = 1'b1;
        // start is held all along: no frame may begin before power-up ends
        step(PWR - 5);
        check(12'(link.select_low), 12'h001);
        check(12'(ready_o), 12'h000);
        step(15);
        check(12'(ready_o), 12'h001);
        start_i = 1'b0;
        for (n = 0; n < 3000 && pos_valid_o !== 1'b1; n++) step(1);
        pop(12'h3c5);
        for (n = 0; n < 200 && busy_o !== 1'b0; n++) step(1);
        $display("power-up test done");
        foreach (vals[i]) frame(vals[i]);
        $display("frame test done");
        // only the low ten bits of the angle travel on the narrow link
        angle_i = 12'ha5c;
        step(2 * SMP + 4);
        check(sample10_o, 12'h25c);
        start10_i = 1'b1;
        for (n = 0; n < 200 && busy10_o !== 1'b1; n++) step(1);
        start10_i = 1'b0;
        for (n = 0; n < 3000 && pos10_valid_o !== 1'b1; n++) step(1);
        check(12'(ready10_o), 12'h001);
        check(12'(pos10_valid_o), 12'h001);
        check(pos10_o, 12'h25c);
        pos10_ready_i = 1'b1;
        step(1);
        pos10_ready_i = 1'b0;
        for (n = 0; n < 200 && busy10_o !== 1'b0; n++) step(1);
        check(12'(pos10_valid_o), 12'h000);
        $display("narrow test done");
        angle_i = 12'h5a3;
        step(2 * SMP);
        start_i = 1'b1;
        q = 0;
        // a full fifo shows as a long idle stretch while start stays high
        for (n = 0; n < 20000 && q < 200; n++)
        begin
            step(1);
            q = (busy_o === 1'b0) ? q + 1 : 0;
        end
        start_i = 1'b0;
        check(12'(link.select_low), 12'h001);
        for (n = 0; n < 8; n++) pop(12'h5a3);
        check(12'(pos_valid_o), 12'h000);
        $display("fifo test done");
        stop_test;
    end
    // the span covers all tests with margin
    initial
    begin
        #400000;
        bad_count++;
        stop_test;
    end
endmodule
